// ---- rtl/irqc_defines.svh ----
// Offsets, field positions, reset values and widths of the interrupt block.
// Assumes inclusion by bare name from the package and the bench.
`ifndef IRQC_DEFINES_SVH
`define IRQC_DEFINES_SVH

// Device register offsets (8-bit space)
`define IRQC_OFS_POWER_CONTROL 8'h87
`define IRQC_OFS_TIMER_CONTROL 8'h88
`define IRQC_OFS_IRQ_ENABLE_SECONDARY 8'ha7
`define IRQC_OFS_IRQ_ENABLE_PRIMARY 8'ha8
`define IRQC_OFS_IRQ_PRIORITY_SECONDARY 8'hb7
`define IRQC_OFS_IRQ_PRIORITY_PRIMARY 8'hb8
`define IRQC_OFS_DISPLAY_CHANNEL_CONTROL 8'hd8
`define IRQC_OFS_UART_FLAGS 8'hd9
`define IRQC_OFS_USB_FLAGS 8'hda
`define IRQC_REG_RESET 8'h00

// Field positions
`define IRQC_PC_IDLE 0
`define IRQC_PC_POWER_DOWN_SELECT 1
`define IRQC_PC_ADC_TAKEOVER 4
`define IRQC_TC_LINE_B_TRIGGER_SELECT 2
`define IRQC_TC_LINE_B_REQUEST_FLAG 3
`define IRQC_EN_GLOBAL 7
`define IRQC_EN_LINE_B 2
`define IRQC_EN_USART1 4
`define IRQC_EN_USB 0
`define IRQC_EN_USART2 4
`define IRQC_EN_DDC 7
`define IRQC_DC_DDC1 0
`define IRQC_DC_SWITCH 1
`define IRQC_DC_SERIAL_STATUS 2
`define IRQC_USB_EVENTS 6

// Controller (AHB-Lite) register byte offsets
`define IRQC_HOFS_CMD 8'h00
`define IRQC_HOFS_RDATA 8'h04
`define IRQC_HOFS_CORE 8'h08
`define IRQC_HOFS_ACK 8'h0c
`define IRQC_HOFS_ISTAT 8'h10
`define IRQC_HOFS_ICLR 8'h14
`define IRQC_HOFS_IEN 8'h18
`define IRQC_CMD_WRITE_BIT 16

`endif

// ---- rtl/irqc_pkg.sv ----
// Types shared by both ends of the interrupt and power-mode block.
// Assumes irqc_defines.svh on the include path.
package irqc_pkg;
  `include "irqc_defines.svh"

  // Power mode of the core
  typedef enum logic [1:0] {
    IRQC_RUN = 2'b00,
    IRQC_IDLE = 2'b01,
    IRQC_PDOWN = 2'b10
  } irqc_mode_t;

  // Interrupt sources, index order is the fixed order within a level
  typedef enum logic [2:0] {
    IRQC_SRC_LINE_B = 3'b000,
    IRQC_SRC_USART1 = 3'b001,
    IRQC_SRC_USB = 3'b010,
    IRQC_SRC_USART2 = 3'b011,
    IRQC_SRC_DDC = 3'b100
  } irqc_src_t;
endpackage

// ---- rtl/irqc_if.sv ----
// Link between the interrupt/power block and the core end.
// Assumes both ends run on the same hclk.
`timescale 1ns/1ps
interface irqc_if;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic irq_req;
  logic [2:0] irq_vec;
  logic irq_ack;
  logic [2:0] ack_vec;
  logic core_halt;
  logic clk_stop;

  modport dev (
    input reg_wr, reg_addr, reg_wdata, irq_ack, ack_vec,
    output reg_rdata, irq_req, irq_vec, core_halt, clk_stop
  );
  modport core (
    output reg_wr, reg_addr, reg_wdata, irq_ack, ack_vec,
    input reg_rdata, irq_req, irq_vec, core_halt, clk_stop
  );
endinterface

// ---- rtl/irqc_device.sv ----
// Interrupt sources and power-saving modes of the microcontroller.
// Assumes peripheral event inputs are one-cycle pulses on hclk, and the
// line-b pin is asynchronous.
`timescale 1ns/1ps
module irqc_device
  import irqc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Core side
  irqc_if.dev core,
  // Peripheral events
  input wire logic line_b_pin_n,
  input wire logic adc_done,
  input wire logic serial_status_set,
  input wire logic ddc1_set,
  input wire logic protocol_switch_set,
  input wire logic [`IRQC_USB_EVENTS-1:0] usb_event,
  input wire logic u1_receive_set,
  input wire logic u1_transmit_set,
  input wire logic u2_receive_set,
  input wire logic u2_transmit_set,
  // Power outputs
  output logic sysclk_stop,
  output logic lvd_run
);

  localparam int NSRC = 5;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;

  // Two flops before any logic looks at the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= line_b_pin_n;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and flags

  logic [7:0] power_control_q, power_control_d;
  logic [7:0] timer_control_q, timer_control_d;
  logic [7:0] en_sec_q, en_sec_d;
  logic [7:0] en_pri_q, en_pri_d;
  logic [7:0] pr_sec_q, pr_sec_d;
  logic [7:0] pr_pri_q, pr_pri_d;
  logic [2:0] ddc_flags_q, ddc_flags_d;
  logic [3:0] uart_flags_q, uart_flags_d;
  logic [`IRQC_USB_EVENTS-1:0] usb_flags_q, usb_flags_d;
  irqc_mode_t mode_q, mode_d;
  logic irq_req_q, irq_req_d;
  logic [2:0] irq_vec_q, irq_vec_d;
  logic [7:0] rdata_q, rdata_d;

  logic [NSRC-1:0] src_flag;
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] src_hi;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] pick;
  logic wr_pc, wr_tc, wr_dc, wr_uf, wr_uu;
  logic take_line_b, take_ddc;
  logic line_b_fall, adc_mode, level_mode;

  // Per-source request, enable and priority bits
  always_comb begin
    src_flag[IRQC_SRC_LINE_B] = timer_control_q[`IRQC_TC_LINE_B_REQUEST_FLAG];
    src_flag[IRQC_SRC_USART1] = |uart_flags_q[1:0];
    src_flag[IRQC_SRC_USB] = |usb_flags_q;
    src_flag[IRQC_SRC_USART2] = |uart_flags_q[3:2];
    src_flag[IRQC_SRC_DDC] = |ddc_flags_q;
    src_en[IRQC_SRC_LINE_B] = en_pri_q[`IRQC_EN_LINE_B];
    src_en[IRQC_SRC_USART1] = en_pri_q[`IRQC_EN_USART1];
    src_en[IRQC_SRC_USB] = en_sec_q[`IRQC_EN_USB];
    src_en[IRQC_SRC_USART2] = en_sec_q[`IRQC_EN_USART2];
    src_en[IRQC_SRC_DDC] = en_sec_q[`IRQC_EN_DDC];
    src_hi[IRQC_SRC_LINE_B] = pr_pri_q[`IRQC_EN_LINE_B];
    src_hi[IRQC_SRC_USART1] = pr_pri_q[`IRQC_EN_USART1];
    src_hi[IRQC_SRC_USB] = pr_sec_q[`IRQC_EN_USB];
    src_hi[IRQC_SRC_USART2] = pr_sec_q[`IRQC_EN_USART2];
    src_hi[IRQC_SRC_DDC] = pr_sec_q[`IRQC_EN_DDC];
  end

  // Next-state computation for every register of the block except the pin synchroniser flops
  always_comb begin
    power_control_d = power_control_q;
    timer_control_d = timer_control_q;
    en_sec_d = en_sec_q;
    en_pri_d = en_pri_q;
    pr_sec_d = pr_sec_q;
    pr_pri_d = pr_pri_q;
    ddc_flags_d = ddc_flags_q;
    uart_flags_d = uart_flags_q;
    usb_flags_d = usb_flags_q;
    mode_d = mode_q;
    irq_vec_d = irq_vec_q;

    wr_pc = core.reg_wr && core.reg_addr == `IRQC_OFS_POWER_CONTROL;
    wr_tc = core.reg_wr && core.reg_addr == `IRQC_OFS_TIMER_CONTROL;
    wr_dc = core.reg_wr &&
            core.reg_addr == `IRQC_OFS_DISPLAY_CHANNEL_CONTROL;
    wr_uf = core.reg_wr && core.reg_addr == `IRQC_OFS_UART_FLAGS;
    wr_uu = core.reg_wr && core.reg_addr == `IRQC_OFS_USB_FLAGS;

    // Plain read/write registers
    if (wr_pc) begin
      power_control_d = core.reg_wdata;
    end
    if (core.reg_wr && core.reg_addr == `IRQC_OFS_IRQ_ENABLE_SECONDARY) begin
      en_sec_d = core.reg_wdata;
    end
    if (core.reg_wr && core.reg_addr == `IRQC_OFS_IRQ_ENABLE_PRIMARY) begin
      en_pri_d = core.reg_wdata;
    end
    if (core.reg_wr &&
        core.reg_addr == `IRQC_OFS_IRQ_PRIORITY_SECONDARY) begin
      pr_sec_d = core.reg_wdata;
    end
    if (core.reg_wr && core.reg_addr == `IRQC_OFS_IRQ_PRIORITY_PRIMARY) begin
      pr_pri_d = core.reg_wdata;
    end
    if (wr_tc) begin
      timer_control_d = core.reg_wdata;
    end

    // Line b request flag; the set terms below override any clear
    take_line_b = core.irq_ack && core.ack_vec == IRQC_SRC_LINE_B;
    adc_mode = power_control_q[`IRQC_PC_ADC_TAKEOVER];
    level_mode = !timer_control_q[`IRQC_TC_LINE_B_TRIGGER_SELECT];
    line_b_fall = pin_prev_q && !pin_sync_q;
    if (adc_mode) begin
      // Conversion done replaces the pin entirely
      if (take_line_b) begin
        timer_control_d[`IRQC_TC_LINE_B_REQUEST_FLAG] = 1'b0;
      end
      if (adc_done) begin
        timer_control_d[`IRQC_TC_LINE_B_REQUEST_FLAG] = 1'b1;
      end
    end else if (level_mode) begin
      // Flag tracks the pin; service does not clear it while the pin is held low
      timer_control_d[`IRQC_TC_LINE_B_REQUEST_FLAG] = !pin_sync_q;
    end else begin
      if (take_line_b) begin
        timer_control_d[`IRQC_TC_LINE_B_REQUEST_FLAG] = 1'b0;
      end
      if (line_b_fall) begin
        timer_control_d[`IRQC_TC_LINE_B_REQUEST_FLAG] = 1'b1;
      end
    end

    // Display channel flags: software clears two, hardware the third
    take_ddc = core.irq_ack && core.ack_vec == IRQC_SRC_DDC;
    if (wr_dc) begin
      ddc_flags_d[1:0] = ddc_flags_q[1:0] & ~core.reg_wdata[1:0];
    end
    if (take_ddc) begin
      ddc_flags_d[`IRQC_DC_SERIAL_STATUS] = 1'b0;
    end
    ddc_flags_d[`IRQC_DC_DDC1] = ddc_flags_d[`IRQC_DC_DDC1] | ddc1_set;
    ddc_flags_d[`IRQC_DC_SWITCH] =
      ddc_flags_d[`IRQC_DC_SWITCH] | protocol_switch_set;
    ddc_flags_d[`IRQC_DC_SERIAL_STATUS] =
      ddc_flags_d[`IRQC_DC_SERIAL_STATUS] | serial_status_set;

    // USART and USB flags are only ever cleared by software
    if (wr_uf) begin
      uart_flags_d = uart_flags_q & ~core.reg_wdata[3:0];
    end
    uart_flags_d = uart_flags_d |
      {u2_transmit_set, u2_receive_set, u1_transmit_set, u1_receive_set};
    if (wr_uu) begin
      usb_flags_d = usb_flags_q &
        ~core.reg_wdata[`IRQC_USB_EVENTS-1:0];
    end
    usb_flags_d = usb_flags_d | usb_event;

    // Gate and arbitrate: high level first, lower index within level
    pend = src_flag & src_en & {NSRC{en_pri_q[`IRQC_EN_GLOBAL]}};
    pick = (|(pend & src_hi)) ? (pend & src_hi) : pend;
    irq_req_d = |pend;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        irq_vec_d = 3'(i);
      end
    end

    // Power modes; the idle bit self-clears on leaving, power-down only ends by reset
    case (mode_q)
      IRQC_RUN: begin
        if (wr_pc && core.reg_wdata[`IRQC_PC_POWER_DOWN_SELECT]) begin
          mode_d = IRQC_PDOWN;
        end else if (wr_pc && core.reg_wdata[`IRQC_PC_IDLE]) begin
          mode_d = IRQC_IDLE;
        end
      end
      IRQC_IDLE: begin
        if (irq_req_q) begin
          mode_d = IRQC_RUN;
          power_control_d[`IRQC_PC_IDLE] = 1'b0;
        end
      end
      IRQC_PDOWN: begin
        mode_d = IRQC_PDOWN;
      end
      default: begin
        mode_d = IRQC_RUN;
      end
    endcase

    // Readback mux, registered
    case (core.reg_addr)
      `IRQC_OFS_POWER_CONTROL: rdata_d = power_control_q;
      `IRQC_OFS_TIMER_CONTROL: rdata_d = timer_control_q;
      `IRQC_OFS_IRQ_ENABLE_SECONDARY: rdata_d = en_sec_q;
      `IRQC_OFS_IRQ_ENABLE_PRIMARY: rdata_d = en_pri_q;
      `IRQC_OFS_IRQ_PRIORITY_SECONDARY: rdata_d = pr_sec_q;
      `IRQC_OFS_IRQ_PRIORITY_PRIMARY: rdata_d = pr_pri_q;
      `IRQC_OFS_DISPLAY_CHANNEL_CONTROL: rdata_d = {5'h00, ddc_flags_q};
      `IRQC_OFS_UART_FLAGS: rdata_d = {4'h0, uart_flags_q};
      `IRQC_OFS_USB_FLAGS: rdata_d = {2'h0, usb_flags_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // Register everything; in power-down the update enable here drops, so the
  // contents simply hold until reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_control_q <= `IRQC_REG_RESET;
      timer_control_q <= `IRQC_REG_RESET;
      en_sec_q <= `IRQC_REG_RESET;
      en_pri_q <= `IRQC_REG_RESET;
      pr_sec_q <= `IRQC_REG_RESET;
      pr_pri_q <= `IRQC_REG_RESET;
      ddc_flags_q <= 3'h0;
      uart_flags_q <= 4'h0;
      usb_flags_q <= '0;
      mode_q <= IRQC_RUN;
      irq_req_q <= 1'b0;
      irq_vec_q <= 3'h0;
      rdata_q <= 8'h00;
    end else if (mode_q != IRQC_PDOWN) begin
      power_control_q <= power_control_d;
      timer_control_q <= timer_control_d;
      en_sec_q <= en_sec_d;
      en_pri_q <= en_pri_d;
      pr_sec_q <= pr_sec_d;
      pr_pri_q <= pr_pri_d;
      ddc_flags_q <= ddc_flags_d;
      uart_flags_q <= uart_flags_d;
      usb_flags_q <= usb_flags_d;
      mode_q <= mode_d;
      irq_req_q <= irq_req_d;
      irq_vec_q <= irq_vec_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Halt only the core in idle; peripherals keep running
  assign core.core_halt = (mode_q == IRQC_IDLE);
  assign core.clk_stop = (mode_q == IRQC_PDOWN);
  assign sysclk_stop = (mode_q == IRQC_PDOWN);
  // Detector supply watch never stops
  assign lvd_run = 1'b1;
  // Requests are masked in power-down so they cannot wake it
  assign core.irq_req = irq_req_q && (mode_q != IRQC_PDOWN);
  assign core.irq_vec = irq_vec_q;
  assign core.reg_rdata = rdata_q;

endmodule // irqc_device

// ---- rtl/irqc_core.sv ----
// Core end: software reaches the interrupt block over AHB-Lite.
// Assumes a single AHB-Lite master, word transfers only, one hclk domain.
`timescale 1ns/1ps
module irqc_core
  import irqc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt to software
  output logic irq,
  // Link to the device
  irqc_if.core dev
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and command registers

  logic wr_ph_q, wr_ph_d;
  logic rd_ph_q, rd_ph_d;
  logic rd_wait_q, rd_wait_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic reg_wr_q, reg_wr_d;
  logic [7:0] reg_addr_q, reg_addr_d;
  logic [7:0] reg_wdata_q, reg_wdata_d;
  logic ack_q, ack_d;
  logic [2:0] ack_vec_q, ack_vec_d;
  logic [1:0] istat_q, istat_d;
  logic [1:0] ien_q, ien_d;
  logic req_prev_q, halt_prev_q;
  logic start;

  // Bus phases, command issue and sticky status
  always_comb begin
    start = hsel && hready && htrans[1];
    wr_ph_d = start && hwrite;
    rd_ph_d = start && !hwrite;
    addr_d = start ? haddr : addr_q;
    rd_wait_d = rd_ph_q && !rd_wait_q;
    hrdata_d = hrdata_q;
    reg_wr_d = 1'b0;
    reg_addr_d = reg_addr_q;
    reg_wdata_d = reg_wdata_q;
    ack_d = 1'b0;
    ack_vec_d = ack_vec_q;
    ien_d = ien_q;
    istat_d = istat_q;
    if (wr_ph_q) begin
      case (addr_q)
        `IRQC_HOFS_CMD: begin
          reg_addr_d = hwdata[15:8];
          reg_wdata_d = hwdata[7:0];
          reg_wr_d = hwdata[`IRQC_CMD_WRITE_BIT];
        end
        `IRQC_HOFS_ACK: begin
          ack_d = dev.irq_req;
          ack_vec_d = dev.irq_vec;
        end
        `IRQC_HOFS_ICLR: istat_d = istat_q & ~hwdata[1:0];
        `IRQC_HOFS_IEN: ien_d = hwdata[1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    istat_d[0] = istat_d[0] | (dev.irq_req && !req_prev_q);
    istat_d[1] = istat_d[1] | (halt_prev_q && !dev.core_halt);
    // Sample read data one cycle late so a preceding write is seen
    if (rd_ph_q && !rd_wait_q) begin
      case (addr_q)
        `IRQC_HOFS_CMD: hrdata_d = {16'h0000, reg_addr_q, reg_wdata_q};
        `IRQC_HOFS_RDATA: hrdata_d = {24'h000000, dev.reg_rdata};
        `IRQC_HOFS_CORE: hrdata_d = {26'h0000000, dev.clk_stop,
                                     dev.core_halt, dev.irq_vec, dev.irq_req};
        `IRQC_HOFS_ISTAT: hrdata_d = {30'h00000000, istat_q};
        `IRQC_HOFS_IEN: hrdata_d = {30'h00000000, ien_q};
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      reg_wr_q <= 1'b0;
      reg_addr_q <= 8'h00;
      reg_wdata_q <= 8'h00;
      ack_q <= 1'b0;
      ack_vec_q <= 3'h0;
      istat_q <= 2'h0;
      ien_q <= 2'h0;
      req_prev_q <= 1'b0;
      halt_prev_q <= 1'b0;
    end else begin
      wr_ph_q <= wr_ph_d;
      rd_ph_q <= rd_ph_d | (rd_ph_q && !rd_wait_q);
      rd_wait_q <= rd_wait_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      reg_wr_q <= reg_wr_d;
      reg_addr_q <= reg_addr_d;
      reg_wdata_q <= reg_wdata_d;
      ack_q <= ack_d;
      ack_vec_q <= ack_vec_d;
      istat_q <= istat_d;
      ien_q <= ien_d;
      req_prev_q <= dev.irq_req;
      halt_prev_q <= dev.core_halt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Reads stretch by one wait state
  assign hreadyout = !(rd_ph_q && !rd_wait_q);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign irq = |(istat_q & ien_q);
  assign dev.reg_wr = reg_wr_q;
  assign dev.reg_addr = reg_addr_q;
  assign dev.reg_wdata = reg_wdata_q;
  assign dev.irq_ack = ack_q;
  assign dev.ack_vec = ack_vec_q;

endmodule // irqc_core

// ---- test/irqc_checker.sv ----
// Concurrent checks on the link between the device end and the core end.
// Assumes one hclk domain; the bench wires the link signals in by name.
`timescale 1ns/1ps
module irqc_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link signals
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic irq_req,
  input wire logic [2:0] irq_vec,
  input wire logic core_halt,
  input wire logic clk_stop
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Write decodes, kept apart so each property stays short
  wire logic pctl_wr = reg_wr && reg_addr == 8'h87;
  wire logic gen_off = reg_wr && reg_addr == 8'ha8 && !reg_wdata[7];

  ////////////////////////////////////////////////////////////////////////////
  // Power-down masks requests and is never left without reset
  chk_pdown_masks_req: assert property (clk_stop |-> !irq_req)
    else $error("request seen in power-down");
  chk_pdown_holds: assert property (clk_stop |=> clk_stop)
    else $error("power-down left without reset");
  chk_pdown_freeze: assert property (
    clk_stop && $past(clk_stop) |-> $stable(irq_vec))
    else $error("vector moved in power-down");
  chk_modes_apart: assert property (!(core_halt && clk_stop))
    else $error("idle and power-down together");
  // Idle ends soon after a request; a slow exit would stall the core
  chk_idle_exit: assert property (
    core_halt && irq_req |-> ##[0:2] !core_halt)
    else $error("idle kept despite request");
  chk_pdown_entry: assert property (
    pctl_wr && reg_wdata[1] && !clk_stop |-> ##[1:3] clk_stop)
    else $error("power-down not entered");
  chk_idle_entry: assert property (
    pctl_wr && reg_wdata[0] && !reg_wdata[1] && !clk_stop
    |-> ##[1:3] (core_halt || irq_req))
    else $error("idle not entered");
  chk_global_gate: assert property (
    gen_off && !clk_stop |-> ##[1:2] !irq_req)
    else $error("request despite global disable");
  chk_vec_range: assert property (irq_req |-> irq_vec <= 3'd4)
    else $error("request vector out of range");
endmodule // irqc_checker

// ---- test/irqc_tb.sv ----
// Bench joining the device end and the core end through the link.
// Assumes the design files and irqc_defines.svh are compiled ahead of it.
`timescale 1ns/1ps
`include "irqc_defines.svh"
module irqc_tb;
  import irqc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, pin_n, hreadyout, hresp, irq;
  logic sysclk_stop, lvd_run;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [13:0] ev;
  int error_cnt, compares;
  // Device offset, written byte, byte read back
  logic [23:0] rows [5] = '{24'ha79191, 24'ha81414, 24'hb79191,
    24'hb81414, 24'h880404};

  irqc_if lnk();
  irqc_device i_irqc_device (.hclk(hclk), .hresetn(hresetn), .core(lnk),
    .line_b_pin_n(pin_n), .adc_done(ev[0]), .serial_status_set(ev[1]),
    .ddc1_set(ev[2]), .protocol_switch_set(ev[3]), .usb_event(ev[13:8]),
    .u1_receive_set(ev[4]), .u1_transmit_set(ev[5]),
    .u2_receive_set(ev[6]), .u2_transmit_set(ev[7]),
    .sysclk_stop(sysclk_stop), .lvd_run(lvd_run));
  irqc_core i_irqc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .dev(lnk));
  irqc_checker i_irqc_checker (.hclk(hclk), .hresetn(hresetn),
    .reg_wr(lnk.reg_wr), .reg_addr(lnk.reg_addr),
    .reg_wdata(lnk.reg_wdata), .irq_req(lnk.irq_req),
    .irq_vec(lnk.irq_vec), .core_halt(lnk.core_halt),
    .clk_stop(lnk.clk_stop));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus helpers
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Looks at hreadyout mid-cycle, the value the next rising edge samples
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      chk("hready_wait", 32'h0, 32'h1);
      print_verdict();
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    @(posedge hclk);
  endtask

  task dev_wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, `IRQC_HOFS_CMD, {15'h0, 1'b1, a, d});
  endtask

  task dev_rd(input logic [7:0] a);
    ahb(1'b1, `IRQC_HOFS_CMD, {16'h0, a, 8'h00});
    ahb(1'b0, `IRQC_HOFS_RDATA, 32'h0);
  endtask

  // Bounded poll of the core status word; the vector field keeps the
  // last winner after the request drops, so idle values carry it
  task poll(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      ahb(1'b0, `IRQC_HOFS_CORE, 32'h0);
      n++;
    end while (rd !== e && n < 30);
    chk("core", rd, e);
  endtask

  task pulse(input logic [13:0] m);
    ev <= m;
    @(posedge hclk);
    ev <= '0;
    @(posedge hclk);
  endtask

  task ack;
    ahb(1'b1, `IRQC_HOFS_ACK, 32'h0);
  endtask

  task settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask

  task do_reset;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    pin_n = 1'b1;
    ev = '0;
    error_cnt = 0;
    compares = 0;
    do_reset();
    // Reset values, then the read-write table
    for (int i = 0; i < 5; i++) begin
      dev_rd(rows[i][23:16]);
      chk("reset_val", rd, 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      dev_wr(rows[i][23:16], rows[i][15:8]);
      dev_rd(rows[i][23:16]);
      chk("reg_rw", rd, {24'h0, rows[i][7:0]});
    end
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    do_reset();
    ahb(1'b1, `IRQC_HOFS_IEN, 32'h3);
    // First serial port, controller interrupt raised, masked, cleared
    dev_wr(8'ha8, 8'h90);
    pulse(14'h20);
    poll(32'h03);
    ahb(1'b0, `IRQC_HOFS_ISTAT, 32'h0);
    chk("istat", rd & 32'h1, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    ahb(1'b1, `IRQC_HOFS_IEN, 32'h0);
    settle();
    chk("irq_mask", {31'h0, irq}, 32'h0);
    dev_wr(8'hd9, 8'h02);
    poll(32'h02);
    ahb(1'b1, `IRQC_HOFS_ICLR, 32'h3);
    ahb(1'b1, `IRQC_HOFS_IEN, 32'h3);
    settle();
    chk("irq_clr", {31'h0, irq}, 32'h0);
    // Second serial port through the secondary enable
    dev_wr(8'ha7, 8'h10);
    pulse(14'h40);
    poll(32'h07);
    dev_wr(8'hd9, 8'h04);
    poll(32'h06);
    // Simultaneous requests, then priority raised for the bus port
    dev_wr(8'ha7, 8'h11);
    pulse(14'h110);
    poll(32'h03);
    dev_wr(8'hb7, 8'h01);
    poll(32'h05);
    dev_wr(8'hd9, 8'h01);
    dev_wr(8'hda, 8'h01);
    poll(32'h04);
    // Every bus-port event on its own
    for (int i = 0; i < 6; i++) begin
      pulse(14'h100 << i);
      poll(32'h05);
      dev_wr(8'hda, 8'h01 << i);
      poll(32'h04);
    end
    // Display channel: only the serial status flag self-clears
    dev_wr(8'ha7, 8'h80);
    for (int k = 1; k < 4; k++) begin
      pulse(14'h1 << k);
      poll(32'h09);
      ack();
      if (k == 1) begin
        poll(32'h08);
      end else begin
        poll(32'h09);
        dev_wr(8'hd8, 8'(k - 1));
        poll(32'h08);
      end
    end
    // Line b on edges: flag cleared by vectoring
    dev_wr(8'ha8, 8'h84);
    dev_wr(8'h88, 8'h04);
    pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    pin_n <= 1'b1;
    poll(32'h01);
    ack();
    poll(32'h0);
    dev_rd(8'h88);
    chk("edge_flag", rd, 32'h04);
    // Line b on level: request survives vectoring while pin is low
    dev_wr(8'h88, 8'h00);
    pin_n <= 1'b0;
    poll(32'h01);
    ack();
    settle();
    poll(32'h01);
    pin_n <= 1'b1;
    poll(32'h0);
    // Converter takes over line b
    dev_wr(8'h87, 8'h10);
    dev_wr(8'h88, 8'h04);
    pulse(14'h1);
    poll(32'h01);
    ack();
    poll(32'h0);
    // Idle, left on a request
    dev_wr(8'ha8, 8'h90);
    dev_wr(8'h87, 8'h01);
    poll(32'h10);
    pulse(14'h10);
    poll(32'h03);
    ahb(1'b0, `IRQC_HOFS_ISTAT, 32'h0);
    chk("idle_exit", rd & 32'h2, 32'h2);
    dev_wr(8'hd9, 8'h01);
    poll(32'h02);
    // Power-down ignores requests and ends only by reset
    dev_wr(8'h87, 8'h02);
    poll(32'h22);
    chk("sysclk_stop", {31'h0, sysclk_stop}, 32'h1);
    chk("lvd_run", {31'h0, lvd_run}, 32'h1);
    pulse(14'h10);
    settle();
    poll(32'h22);
    do_reset();
    poll(32'h0);
    dev_rd(8'ha8);
    chk("pd_reset", rd, 32'h0);
    print_verdict();
  end
endmodule // irqc_tb
